//--- verilog/serial_pkg.sv
// Shared constants, types and register map for the two-channel serial port.
// Assumes one oscillator clock and a plain strobe-based register port.
package serial_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int          ADDR_W       = 3;
   localparam int          DATA_W       = 16;
   localparam logic [2:0]  OFS_CH0_CTRL = 3'h0;
   localparam logic [2:0]  OFS_CH0_STAT = 3'h1;
   localparam logic [2:0]  OFS_CH0_DATA = 3'h2;
   localparam logic [2:0]  OFS_CH0_RELD = 3'h3;
   localparam logic [2:0]  OFS_CH1_CTRL = 3'h4;
   localparam logic [2:0]  OFS_CH1_STAT = 3'h5;
   localparam logic [2:0]  OFS_CH1_DATA = 3'h6;
   localparam logic [2:0]  OFS_CH1_RELD = 3'h7;

   // Status bit positions
   localparam int          STAT_RX_DONE = 0;
   localparam int          STAT_TX_DONE = 1;
   localparam int          STAT_RX_BIT9 = 2;
   localparam int          STAT_BUSY    = 3;

   // Control register layout, low six bits of the word
   typedef struct packed {
      logic tx_bit9;
      logic rate_doubling_bit;
      logic generator_select_bit;
      logic rx_enable;
      logic mode_hi_bit;
      logic mode_lo_bit;
   } ctrl_t;
   localparam int          CTRL_W       = 6;
   localparam ctrl_t       CTRL_RESET   = '0;

   ////////////////////////////////////////////////////////////////////////
   // Rate generation
   localparam int          RELOAD_W     = 10;
   localparam logic [9:0]  RELOAD_RESET = 10'h000;
   localparam logic [9:0]  GEN_TOP      = 10'h3ff;
   localparam logic [3:0]  SYNC_LAST    = 4'hb;   // fosc/12 period end
   localparam logic [3:0]  SYNC_MID     = 4'h5;   // rising shift clock
   localparam logic [3:0]  SYNC_HALF    = 4'h6;
   localparam logic [1:0]  FIX_SLOW     = 2'h3;   // 16x tick at fosc/4
   localparam logic [3:0]  OVS_LAST     = 4'hf;   // 16 ticks per bit
   localparam logic [3:0]  OVS_CENTRE   = 4'h7;

   ////////////////////////////////////////////////////////////////////////
   // Frame lengths, as last bit index
   localparam logic [3:0]  SYNC_BITS_LAST = 4'h7;  // 8 shift bits
   localparam logic [3:0]  TX8_LAST       = 4'h9;  // 10-bit frame
   localparam logic [3:0]  TX9_LAST       = 4'ha;  // 11-bit frame
   localparam logic [3:0]  RX8_LAST       = 4'h8;  // samples after start
   localparam logic [3:0]  RX9_LAST       = 4'h9;

   // Engine states, Gray along the usual path except receive data back to idle
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_SYNC = 2'b10
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11
   } rx_state_t;

endpackage : serial_pkg

//--- verilog/dual_serial_port.sv
// Two full-duplex serial channels with rate generators and register port.
// Assumes timer1_overflow is a one-clock pulse from an outside timer and
// that the pad logic resolves the receive pin of channel 0 from its enable.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// One channel: transmit engine (also runs the shift-register mode) and an
// independent asynchronous receive engine.
module serial_channel
   import serial_pkg::*;
#(
   parameter bit HAS_SYNC = 1'b1
)(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // Timing strobes
   input  wire logic       tick16,
   input  wire logic       sync_mid,
   input  wire logic       sync_end,
   input  wire logic       sync_low,
   // Mode and control
   input  wire logic       sync_mode,
   input  wire logic       nine_bit,
   input  wire logic       rx_enable,
   input  wire logic       sync_rx_go,
   input  wire logic       tx_start,
   input  wire logic [8:0] tx_word,
   // Pins
   input  wire logic       rx_pin_in,
   output logic            rx_pin_out,
   output logic            rx_pin_oe,
   output logic            tx_pin,
   // Results
   output logic            tx_done,
   output logic            rx_done,
   output logic [8:0]      rx_word,
   output logic            busy
);
   import serial_pkg::*;

   tx_state_t  tx_state;
   logic [10:0] tx_shift;
   logic [3:0]  tx_tick;
   logic [3:0]  tx_count;
   logic [3:0]  tx_last;
   logic        sync_dir_rx;
   logic        sync_pending;
   logic        sync_done;
   logic [7:0]  sync_word;
   rx_state_t   rx_state;
   logic [9:0]  rx_shift;
   logic [3:0]  rx_tick;
   logic [3:0]  rx_count;
   logic        rx_nine;
   logic        async_done;
   logic [8:0]  async_word;
   logic        use_sync;

   assign use_sync = HAS_SYNC && sync_mode;

   ////////////////////////////////////////////////////////////////////////
   // Transmit engine; in shift-register mode it also receives
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_state     <= TX_IDLE;
         tx_shift     <= '1;
         tx_tick      <= '0;
         tx_count     <= '0;
         tx_last      <= TX8_LAST;
         sync_dir_rx  <= 1'b0;
         sync_pending <= 1'b0;
         tx_done      <= 1'b0;
         sync_done    <= 1'b0;
         sync_word    <= '0;
      end
      else
      begin
         tx_done   <= 1'b0;
         sync_done <= 1'b0;
         unique case (tx_state)
            TX_IDLE:
            begin
               if (use_sync)
               begin
                  // Start only on a period edge so no runt clock appears
                  if (tx_start)
                     sync_pending <= 1'b1;
                  if (sync_end && (sync_pending || tx_start || sync_rx_go))
                  begin
                     sync_dir_rx  <= !(sync_pending || tx_start);
                     tx_shift     <= {3'b111, tx_word[7:0]};
                     tx_count     <= '0;
                     sync_pending <= 1'b0;
                     tx_state     <= TX_SYNC;
                  end
               end
               else if (tx_start)
               begin
                  // Stop, ninth or spare stop, data, start
                  tx_shift <= {1'b1, nine_bit ? tx_word[8] : 1'b1,
                               tx_word[7:0], 1'b0};
                  tx_last  <= nine_bit ? TX9_LAST : TX8_LAST;
                  tx_tick  <= '0;
                  tx_count <= '0;
                  tx_state <= TX_SEND;
               end
            end
            TX_SEND:
            begin
               if (tick16)
               begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == OVS_LAST)
                  begin
                     tx_shift <= {1'b1, tx_shift[10:1]};
                     tx_count <= tx_count + 4'h1;
                     if (tx_count == tx_last)
                     begin
                        tx_done  <= 1'b1;
                        tx_state <= TX_IDLE;
                     end
                  end
               end
            end
            TX_SYNC:
            begin
               // Sample on the rising shift clock, LSB arrives first
               if (sync_mid && sync_dir_rx)
                  tx_shift[7:0] <= {rx_pin_in, tx_shift[7:1]};
               if (sync_end)
               begin
                  if (!sync_dir_rx)
                     tx_shift <= {1'b1, tx_shift[10:1]};
                  tx_count <= tx_count + 4'h1;
                  if (tx_count == SYNC_BITS_LAST)
                  begin
                     tx_done   <= !sync_dir_rx;
                     sync_done <= sync_dir_rx;
                     sync_word <= tx_shift[7:0];
                     tx_state  <= TX_IDLE;
                  end
               end
            end
            default:
               tx_state <= TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Asynchronous receiver, independent of the transmitter
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_state   <= RX_IDLE;
         rx_shift   <= '0;
         rx_tick    <= '0;
         rx_count   <= '0;
         rx_nine    <= 1'b0;
         async_done <= 1'b0;
         async_word <= '0;
      end
      else
      begin
         async_done <= 1'b0;
         unique case (rx_state)
            RX_IDLE:
            begin
               // Falling edge of the start bit, seen at 16x rate
               if (!use_sync && rx_enable && tick16 && !rx_pin_in)
               begin
                  rx_tick  <= '0;
                  rx_nine  <= nine_bit;
                  rx_state <= RX_START;
               end
            end
            RX_START:
            begin
               if (tick16)
               begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == OVS_CENTRE)
                  begin
                     // A glitch that is high again at mid-bit is dropped
                     rx_tick  <= '0;
                     rx_count <= '0;
                     rx_state <= rx_pin_in ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA:
            begin
               if (tick16)
               begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == OVS_LAST)
                  begin
                     rx_shift <= {rx_pin_in, rx_shift[9:1]};
                     rx_count <= rx_count + 4'h1;
                     if (rx_count == (rx_nine ? RX9_LAST : RX8_LAST))
                     begin
                        // Frame kept only with a high stop bit
                        async_done <= rx_pin_in;
                        async_word <= rx_nine ? rx_shift[9:1]
                                              : {1'b0, rx_shift[9:2]};
                        rx_state   <= RX_IDLE;
                     end
                  end
               end
            end
            default:
               rx_state <= RX_IDLE;
         endcase
      end
   end

   // Pins: shift clock idles high and is low in the first half period
   assign tx_pin     = (tx_state == TX_SEND) ? tx_shift[0] :
                       (tx_state == TX_SYNC) ? !sync_low : 1'b1;
   assign rx_pin_oe  = (tx_state == TX_SYNC) && !sync_dir_rx;
   assign rx_pin_out = tx_shift[0];
   assign rx_done    = sync_done | async_done;
   assign rx_word    = sync_done ? {1'b0, sync_word} : async_word;
   assign busy       = (tx_state != TX_IDLE) || sync_pending;

endmodule : serial_channel

////////////////////////////////////////////////////////////////////////////
// Top: registers, rate generation and two channels
module dual_serial_port (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        resetn,
   // Register port
   input  wire logic [serial_pkg::ADDR_W-1:0] address,
   input  wire logic [serial_pkg::DATA_W-1:0] write_data,
   input  wire logic                        write_strobe,
   input  wire logic                        read_strobe,
   output logic      [serial_pkg::DATA_W-1:0] read_data,
   // Timer 1 overflow pulse
   input  wire logic                        timer1_overflow,
   // Channel 0 pins
   input  wire logic                        rx_data_pin_0_in,
   output logic                             rx_data_pin_0_out,
   output logic                             rx_data_pin_0_oe,
   output logic                             tx_data_pin_0,
   // Channel 1 pins
   input  wire logic                        rx_data_pin_1,
   output logic                             tx_data_pin_1,
   // Service requests
   output logic                             chan0_request,
   output logic                             chan1_request
);
   import serial_pkg::*;

   ctrl_t               chan0_control_reg;
   ctrl_t               chan1_control_reg;
   logic [RELOAD_W-1:0] reload0;
   logic [RELOAD_W-1:0] reload1;
   logic [RELOAD_W-1:0] gen0;
   logic [RELOAD_W-1:0] gen1;
   logic                gen0_ovf;
   logic                gen1_ovf;
   logic [3:0]          sync_cnt;
   logic [1:0]          fix_cnt;
   logic                half0;
   logic                var_src0;
   logic                tick0;
   logic                fix_tick;
   logic                chan0_rx_done_flag;
   logic                chan0_tx_done_flag;
   logic                chan1_rx_done_flag;
   logic                chan1_tx_done_flag;
   logic                rx_bit9_0;
   logic                rx_bit9_1;
   logic [8:0]          rx_buf0;
   logic [8:0]          rx_buf1;
   logic                tx_done0, rx_done0, busy0;
   logic                tx_done1, rx_done1, busy1;
   logic [8:0]          rx_word0, rx_word1;
   logic                sync_mode0;
   logic                wr_ctrl0, wr_stat0, wr_data0, wr_reld0;
   logic                wr_ctrl1, wr_stat1, wr_data1, wr_reld1;

   assign sync_mode0 = !chan0_control_reg.mode_hi_bit
                     && !chan0_control_reg.mode_lo_bit;
   assign wr_ctrl0 = write_strobe && (address == OFS_CH0_CTRL);
   assign wr_stat0 = write_strobe && (address == OFS_CH0_STAT);
   assign wr_data0 = write_strobe && (address == OFS_CH0_DATA);
   assign wr_reld0 = write_strobe && (address == OFS_CH0_RELD);
   assign wr_ctrl1 = write_strobe && (address == OFS_CH1_CTRL);
   assign wr_stat1 = write_strobe && (address == OFS_CH1_STAT);
   assign wr_data1 = write_strobe && (address == OFS_CH1_DATA);
   assign wr_reld1 = write_strobe && (address == OFS_CH1_RELD);

   ////////////////////////////////////////////////////////////////////////
   // Control and reload registers
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         chan0_control_reg <= CTRL_RESET;
         chan1_control_reg <= CTRL_RESET;
         reload0           <= RELOAD_RESET;
         reload1           <= RELOAD_RESET;
      end
      else
      begin
         if (wr_ctrl0)
            chan0_control_reg <= ctrl_t'(write_data[CTRL_W-1:0]);
         if (wr_ctrl1)
            chan1_control_reg <= ctrl_t'(write_data[CTRL_W-1:0]);
         if (wr_reld0)
            reload0 <= write_data[RELOAD_W-1:0];
         if (wr_reld1)
            reload1 <= write_data[RELOAD_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fixed dividers: fosc/12 shift clock and fosc/2 or fosc/4 16x tick
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_cnt <= '0;
         fix_cnt  <= '0;
      end
      else
      begin
         sync_cnt <= (sync_cnt == SYNC_LAST) ? 4'h0
                                             : sync_cnt + 4'h1;
         fix_cnt  <= fix_cnt + 2'h1;
      end
   end

   // Mode 2 bit clock is fosc/64 or fosc/32 after the divide by 16
   assign fix_tick = chan0_control_reg.rate_doubling_bit ? fix_cnt[0]
                   : (fix_cnt == FIX_SLOW);

   ////////////////////////////////////////////////////////////////////////
   // Dedicated 10-bit auto-reload generators
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         gen0 <= RELOAD_RESET;
         gen1 <= RELOAD_RESET;
      end
      else
      begin
         gen0 <= gen0_ovf ? reload0 : gen0 + 10'h001;
         gen1 <= gen1_ovf ? reload1 : gen1 + 10'h001;
      end
   end
   assign gen0_ovf = (gen0 == GEN_TOP);
   assign gen1_ovf = (gen1 == GEN_TOP);

   ////////////////////////////////////////////////////////////////////////
   // Channel 0 source select and optional halving
   assign var_src0 = chan0_control_reg.generator_select_bit ? gen0_ovf
                   : timer1_overflow;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         half0 <= 1'b0;
      else if (var_src0)
         half0 <= !half0;
   end

   // Doubling bit clear passes every second source pulse
   assign tick0 = chan0_control_reg.mode_hi_bit
                  && !chan0_control_reg.mode_lo_bit ? fix_tick
                : var_src0 && (chan0_control_reg.rate_doubling_bit
                  || half0);

   ////////////////////////////////////////////////////////////////////////
   // Done flags: a hardware set wins over a software clear
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         chan0_rx_done_flag <= 1'b0;
         chan0_tx_done_flag <= 1'b0;
         chan1_rx_done_flag <= 1'b0;
         chan1_tx_done_flag <= 1'b0;
      end
      else
      begin
         chan0_rx_done_flag <= rx_done0 || (chan0_rx_done_flag
            && !(wr_stat0 && write_data[STAT_RX_DONE]));
         chan0_tx_done_flag <= tx_done0 || (chan0_tx_done_flag
            && !(wr_stat0 && write_data[STAT_TX_DONE]));
         chan1_rx_done_flag <= rx_done1 || (chan1_rx_done_flag
            && !(wr_stat1 && write_data[STAT_RX_DONE]));
         chan1_tx_done_flag <= tx_done1 || (chan1_tx_done_flag
            && !(wr_stat1 && write_data[STAT_TX_DONE]));
      end
   end

   // Receive buffers and ninth bits
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_buf0 <= '0;
         rx_buf1 <= '0;
      end
      else
      begin
         if (rx_done0)
            rx_buf0 <= rx_word0;
         if (rx_done1)
            rx_buf1 <= rx_word1;
      end
   end
   assign rx_bit9_0     = rx_buf0[8];
   assign rx_bit9_1     = rx_buf1[8];
   assign chan0_request = chan0_rx_done_flag || chan0_tx_done_flag;
   assign chan1_request = chan1_rx_done_flag || chan1_tx_done_flag;

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe, unused bits read zero
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         read_data <= '0;
      else
      begin
         read_data <= '0;
         if (read_strobe)
            unique case (address)
               OFS_CH0_CTRL: read_data[CTRL_W-1:0] <= chan0_control_reg;
               OFS_CH0_STAT: read_data[3:0] <= {busy0, rx_bit9_0,
                  chan0_tx_done_flag, chan0_rx_done_flag};
               OFS_CH0_DATA: read_data[7:0] <= rx_buf0[7:0];
               OFS_CH0_RELD: read_data[RELOAD_W-1:0] <= reload0;
               OFS_CH1_CTRL: read_data[CTRL_W-1:0] <= chan1_control_reg;
               OFS_CH1_STAT: read_data[3:0] <= {busy1, rx_bit9_1,
                  chan1_tx_done_flag, chan1_rx_done_flag};
               OFS_CH1_DATA: read_data[7:0] <= rx_buf1[7:0];
               OFS_CH1_RELD: read_data[RELOAD_W-1:0] <= reload1;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel 0: all four modes, ninth bit when the high mode bit is set
   serial_channel #(.HAS_SYNC(1'b1)) u_chan0 (
      .clock      (clock),
      .resetn     (resetn),
      .tick16     (tick0),
      .sync_mid   (sync_cnt == SYNC_MID),
      .sync_end   (sync_cnt == SYNC_LAST),
      .sync_low   (sync_cnt < SYNC_HALF),
      .sync_mode  (sync_mode0),
      .nine_bit   (chan0_control_reg.mode_hi_bit),
      .rx_enable  (chan0_control_reg.rx_enable),
      .sync_rx_go (chan0_control_reg.rx_enable && !chan0_rx_done_flag),
      .tx_start   (wr_data0),
      .tx_word    ({chan0_control_reg.tx_bit9, write_data[7:0]}),
      .rx_pin_in  (rx_data_pin_0_in),
      .rx_pin_out (rx_data_pin_0_out),
      .rx_pin_oe  (rx_data_pin_0_oe),
      .tx_pin     (tx_data_pin_0),
      .tx_done    (tx_done0),
      .rx_done    (rx_done0),
      .rx_word    (rx_word0),
      .busy       (busy0)
   );

   // Channel 1: async only, mode bit 0 clear selects the 9-bit frame
   serial_channel #(.HAS_SYNC(1'b0)) u_chan1 (
      .clock      (clock),
      .resetn     (resetn),
      .tick16     (gen1_ovf),
      .sync_mid   (1'b0),
      .sync_end   (1'b0),
      .sync_low   (1'b0),
      .sync_mode  (1'b0),
      .nine_bit   (!chan1_control_reg.mode_lo_bit),
      .rx_enable  (chan1_control_reg.rx_enable),
      .sync_rx_go (1'b0),
      .tx_start   (wr_data1),
      .tx_word    ({chan1_control_reg.tx_bit9, write_data[7:0]}),
      .rx_pin_in  (rx_data_pin_1),
      .rx_pin_out (),
      .rx_pin_oe  (),
      .tx_pin     (tx_data_pin_1),
      .tx_done    (tx_done1),
      .rx_done    (rx_done1),
      .rx_word    (rx_word1),
      .busy       (busy1)
   );

endmodule : dual_serial_port

//--- sim/serial_props.sv
// Checker on the serial port's top ports.
// Assumes one clock domain; bound to every dual_serial_port.
`timescale 1ns/10ps
module serial_props (
   // Clock, reset and register port
   input wire logic                          clock,
   input wire logic                          resetn,
   input wire logic [serial_pkg::ADDR_W-1:0] address,
   input wire logic                          write_strobe,
   input wire logic                          read_strobe,
   input wire logic [serial_pkg::DATA_W-1:0] read_data,
   // Pins and requests
   input wire logic                          rx_data_pin_0_oe,
   input wire logic                          tx_data_pin_0,
   input wire logic                          tx_data_pin_1,
   input wire logic                          chan0_request,
   input wire logic                          chan1_request
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////
   a_read_quiet:
      assert property (!read_strobe |=> read_data == '0) else $error("bus");
   a_req0_hold:
      assert property (chan0_request && !(write_strobe && address == 3'h1)
         |=> chan0_request) else $error("req0 dropped");
   a_req1_hold:
      assert property (chan1_request && !(write_strobe && address == 3'h5)
         |=> chan1_request) else $error("req1 dropped");
   a_reset_idle:
      assert property ($rose(resetn) |-> tx_data_pin_0 && tx_data_pin_1 &&
         !rx_data_pin_0_oe && !chan0_request) else $error("not idle");
   a_tx0_low_len:
      assert property ($fell(tx_data_pin_0) |-> !tx_data_pin_0[*6])
         else $error("ch0 low short");
   a_tx0_high_len:
      assert property ($rose(tx_data_pin_0) |-> tx_data_pin_0[*6])
         else $error("ch0 high short");
   a_tx1_low_len:
      assert property ($fell(tx_data_pin_1) |-> !tx_data_pin_1[*8])
         else $error("ch1 low short");
   a_tx1_high_len:
      assert property ($rose(tx_data_pin_1) |-> tx_data_pin_1[*8])
         else $error("ch1 high short");
endmodule : serial_props
bind dual_serial_port serial_props u_props (.*);

//--- sim/remote_serial.sv
// Remote serial device: sends one frame on go, records the last frame.
// Assumes bit_clocks is the bit length in oscillator clocks.
`timescale 1ns/10ps
module remote_serial (
   // Set-up
   input  wire logic       clock,
   input  wire logic [7:0] bit_clocks,
   input  wire logic       nine,
   input  wire logic       go,
   input  wire logic [8:0] send_word,
   // Line
   input  wire logic       line_in,
   output logic            line_out,
   output logic [9:0]      heard
);
   int i;
   int j;
   initial line_out = 1'b1;
   // Start low, data LSB first, stop high
   always @(posedge clock)
      if (go)
      begin
         line_out <= 1'b0;
         for (i = 0; i <= (nine ? 9 : 8); i++)
         begin
            repeat (bit_clocks) @(posedge clock);
            line_out <= (i == (nine ? 9 : 8)) | send_word[i % 9];
         end
      end
   // Mid-bit sampling; heard ends as {stop, data} shifted in LSB first
   always
   begin
      @(negedge line_in);
      heard = '0;
      repeat (bit_clocks / 2) @(posedge clock);
      for (j = 0; j <= (nine ? 9 : 8); j++)
      begin
         repeat (bit_clocks) @(posedge clock);
         heard = {line_in, heard[9:1]};
      end
   end
endmodule : remote_serial

//--- sim/test_dual_serial_port.sv
// Bench: register tasks and full-duplex frames against a remote device.
// Assumes the remote model drives both receive pins; timer 1 pulses every
// fourth clock.
`timescale 1ns/10ps
module test_dual_serial_port;
   import serial_pkg::*;
   logic        clock, resetn, write_strobe, read_strobe, go, nine, sel;
   logic [2:0]  address;
   logic [15:0] write_data, read_data, v;
   logic [8:0]  send_word;
   logic [9:0]  heard;
   logic [7:0]  bit_clocks, got;
   logic        oe, tx0, tx1, line, req0, req1, dout;
   int          fail_count = 0, checks_done = 0, cycles = 0, n;
   dual_serial_port u_dut (.clock(clock), .resetn(resetn),
      .address(address), .write_data(write_data), .read_data(read_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe),
      .timer1_overflow(cycles[1:0] == 2'h0), .rx_data_pin_0_in(line),
      .rx_data_pin_0_out(dout), .rx_data_pin_0_oe(oe), .tx_data_pin_0(tx0),
      .rx_data_pin_1(line), .tx_data_pin_1(tx1),
      .chan0_request(req0), .chan1_request(req1));
   remote_serial u_far (.clock(clock), .bit_clocks(bit_clocks), .go(go),
      .nine(nine), .send_word(send_word), .line_in(sel ? tx1 : tx0),
      .line_out(line), .heard(heard));
   // Mode 0 data out, taken on each rising shift clock
   always @(posedge tx0)
      if (oe)
         got <= {dout, got[7:1]};
   ////////////////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      address      <= a;
      write_data   <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] a);
      @(posedge clock);
      address     <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 v = read_data;
   endtask : rd
   // One frame each way at once, then flags, data and clearing
   task run(input logic [2:0] b, input logic [15:0] c, input logic [7:0] bc,
            input logic nn, input logic [8:0] tw, input logic [8:0] pw);
      wr(b + 3'h3, 16'h03fc);
      repeat (1030) @(posedge clock); // Generator must reload once first
      wr(b, c | 16'h0004 | {10'h0, tw[8], 5'h0});
      {sel, bit_clocks, nine, send_word} <= {b[2], bc, nn, pw};
      wr(b + 3'h2, {8'h0, tw[7:0]});
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      v = '0;
      for (n = 0; n < 1000 && v[1:0] != 2'h3; n++)
         rd(b + 3'h1);
      check(v, {13'h0, nn & pw[8], 2'h3});
      check(nn ? {7'h1, tw} : {7'h1, tw[7:0], 1'b0},
            {6'h0, heard});
      check({15'h0, b[2] ? req1 : req0}, 16'h0001);
      rd(b + 3'h2);
      check(v, {8'h0, pw[7:0]});
      wr(b + 3'h1, 16'h0003);
      rd(b + 3'h1);
      check(v, {13'h0, nn & pw[8], 2'h0});
   endtask : run
   task conclude;
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         conclude();
      end
   end
   // Reset, reset values, then every channel mode
   initial
   begin
      {resetn, write_strobe, read_strobe, go, nine, sel} = '0;
      {address, write_data, send_word, bit_clocks} = '0;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         rd(k[2:0]);
         check(v, 16'h0000);
      end
      run(3'h4, 16'h0001, 8'd64, 1'b0, 9'h0a5, 9'h03c);
      run(3'h4, 16'h0000, 8'd64, 1'b1, 9'h15a, 9'h1c3);
      run(3'h0, 16'h0012, 8'd32, 1'b1, 9'h1a5, 9'h13c);
      run(3'h0, 16'h001b, 8'd64, 1'b1, 9'h0c3, 9'h05a);
      run(3'h0, 16'h0001, 8'd128, 1'b0, 9'h03c, 9'h0c3);
      // Mode 0 last: its shift clock also upsets the remote receiver
      wr(3'h0, 16'h0000);
      wr(3'h2, 16'h00a5);
      v = '0;
      for (n = 0; n < 100 && !v[1]; n++)
         rd(3'h1);
      check(v, 16'h0002);
      check({8'h0, got}, 16'h00a5);
      conclude();
   end
endmodule : test_dual_serial_port
